// file: verilog/twi_cfg.svh
`ifndef TWI_CFG_SVH
`define TWI_CFG_SVH
`define TWI_DIV_W 8
`define TWI_PRE_W 9
`define TWI_UNIT_ONE 4'h1
`define TWI_LOW_UNITS 4'h6
`define TWI_HIGH_END 4'hA
`define TWI_SEQ_END 4'hE
`define TWI_ACK_BIT 4'h8
`define TWI_FIFO_DEPTH 8
`endif

// file: verilog/twi_pkg.sv
`include "twi_cfg.svh"
package twi_pkg;
  typedef enum logic [1:0] {OP_START = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2, OP_STOP = 2'h3} op_t;
  typedef struct packed {
    op_t op;
    logic last;
    logic [6:0] addr;
    logic dir;
    logic [7:0] data;
  } cmd_t;
  typedef struct packed {
    logic [7:0] data;
    logic nack;
    logic lost;
  } rsp_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_HOLD = 5'h02, S_START = 5'h04, S_BIT = 5'h08, S_STOP = 5'h10
  } st_t;
  typedef struct packed {
    st_t st;
    logic [3:0] unit;
    logic [3:0] bitn;
    logic [`TWI_PRE_W-1:0] pre;
    logic [7:0] sh;
    cmd_t cmd;
    logic sda_oe;
    logic scl_oe;
    logic busy;
    logic [1:0] sda_sy;
    logic [1:0] scl_sy;
    logic sda_prev;
    logic scl_prev;
    rsp_t rsp;
    logic rsp_valid;
  } eng_t;
endpackage : twi_pkg

// file: verilog/twi_master_engine.sv
// Functional notes
// R1: Bus idle when both lines sampled high.
// R2: Byte slot is eight data plus ack.
// R3: Bytes shift MSB first, each acknowledged.
// R4: Wait while receiver holds clock low.
// R5: START/STOP are data edges, clock high.
// R6: Busy set on START, cleared on STOP.
// R7: Address byte is seven bits plus direction.
// R8: End with STOP or repeated START.
// R9: Data changes only while clock low.
// R10: Master clocks ack; transmitter releases data.
// R11: Receiver pulls data low to acknowledge.
// R12: Address not acknowledged leads to STOP.
// R13: Master receiver leaves last byte unacknowledged.
// R14: New transfer starts only on idle bus.
// R15: Losing master releases lines, waits idle.
// R16: Arbitration continues through address and data.
// R17: Clock low six units, high four.
// R18: Period is 2*(1+div)*10 system clocks.
// R19: Divider value comes from programmed input.
// R20: Divider selects standard or fast rate.
// R21: Prescaler advances unit every 2*(div+1).
`timescale 1ns/1ps
`include "twi_cfg.svh"

module twi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `TWI_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : twi_fifo

module twi_master_engine #(
  parameter int DEPTH = `TWI_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`TWI_DIV_W-1:0] clock_divider_value,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire twi_pkg::cmd_t cmd,
  output logic rsp_valid,
  output twi_pkg::rsp_t rsp,
  output logic bus_busy,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe
);
  import twi_pkg::*;

  eng_t q;
  eng_t d;
  cmd_t c;
  logic c_valid;
  logic c_ready;
  logic sda_s;
  logic scl_s;
  logic start_det;
  logic stop_det;
  logic bus_idle;
  logic tick;
  logic adv;
  logic [3:0] un;

  // Commands queue up so software can stage a whole transfer ahead of the bus
  twi_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(DEPTH)) u_cmd_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(c_valid),
    .out_ready(c_ready),
    .out_data(c)
  );

  // Whether to pull the data line low for the coming bit
  function automatic logic drive_low(st_t st, cmd_t cm, logic [3:0] bn, logic [7:0] sh);
    logic r;
    r = 1'b0;
    if (st == S_STOP) begin
      r = 1'b1;
    end else if (st == S_BIT) begin
      if (bn == `TWI_ACK_BIT) begin
        r = (cm.op == OP_READ) && !cm.last; // R10 R11 R13
      end else begin
        r = (cm.op != OP_READ) && !sh[7]; // R3
      end
    end
    return r;
  endfunction : drive_low

  assign sda_s = q.sda_sy[1];
  assign scl_s = q.scl_sy[1];
  assign start_det = scl_s && q.scl_prev && q.sda_prev && !sda_s; // R5
  assign stop_det = scl_s && q.scl_prev && !q.sda_prev && sda_s; // R5
  assign bus_idle = sda_s && scl_s && !q.busy; // R1
  assign tick = q.pre == '0;
  // Clock stretch: high phase units only count once the line is seen high
  assign adv = tick && !(q.unit >= `TWI_LOW_UNITS && !scl_s && !q.scl_oe); // R4
  assign un = q.unit + `TWI_UNIT_ONE;
  assign c_ready = (q.st == S_HOLD) || (q.st == S_IDLE && (bus_idle || c.op != OP_START)); // R14

  always_comb begin
    d = q;
    d.sda_sy = {q.sda_sy[0], serial_data_pin_in};
    d.scl_sy = {q.scl_sy[0], serial_clock_pin_in};
    d.sda_prev = sda_s;
    d.scl_prev = scl_s;
    d.rsp_valid = 1'b0;
    if (start_det) begin
      d.busy = 1'b1; // R6
    end else if (stop_det) begin
      d.busy = 1'b0; // R6
    end
    d.pre = tick ? {clock_divider_value, 1'b1} : q.pre - `TWI_PRE_W'(1); // R18 R19 R20 R21
    case (q.st)
      S_IDLE: begin
        d.sda_oe = 1'b0; // R15
        d.scl_oe = 1'b0;
        if (c_valid && c_ready && c.op == OP_START) begin
          d.cmd = c;
          d.sh = {c.addr, c.dir}; // R7
          d.st = S_START;
          // Bit count may be left mid-byte by a lost arbitration
          d.bitn = '0;
          d.unit = `TWI_LOW_UNITS;
        end
      end
      S_HOLD: begin
        if (c_valid) begin
          d.cmd = c;
          d.unit = '0;
          d.bitn = '0;
          d.sh = (c.op == OP_START) ? {c.addr, c.dir} : c.data;
          case (c.op)
            OP_START: d.st = S_START; // R8
            OP_STOP: d.st = S_STOP; // R8
            default: d.st = S_BIT;
          endcase
        end
      end
      S_START, S_BIT, S_STOP: begin
        if (adv) begin
          d.unit = un;
          if (un == `TWI_UNIT_ONE) begin
            d.sda_oe = drive_low(q.st, q.cmd, q.bitn, q.sh); // R9
          end
          if (un == `TWI_LOW_UNITS) begin
            d.scl_oe = 1'b0; // R17
          end
          if (un == `TWI_HIGH_END) begin
            if (q.st == S_START) begin
              d.sda_oe = 1'b1; // R5
            end else if (q.st == S_STOP) begin
              d.sda_oe = 1'b0; // R5
            end else begin
              d.scl_oe = 1'b1; // R17
              d.unit = '0;
              d.bitn = q.bitn + 4'h1;
              if (q.bitn != `TWI_ACK_BIT) begin
                d.sh = {q.sh[6:0], sda_s}; // R3
              end
              if (q.bitn != `TWI_ACK_BIT && q.cmd.op != OP_READ && !q.sda_oe && !sda_s) begin
                d.sda_oe = 1'b0; // R15 R16
                d.scl_oe = 1'b0;
                d.st = S_IDLE;
                d.rsp = '{data: q.sh, nack: 1'b0, lost: 1'b1};
                d.rsp_valid = 1'b1;
              end
              if (q.bitn == `TWI_ACK_BIT) begin
                d.bitn = '0; // R2
                d.rsp = '{data: q.sh, nack: sda_s, lost: 1'b0};
                d.rsp_valid = 1'b1;
                d.st = (q.cmd.op == OP_START && sda_s) ? S_STOP : S_HOLD; // R12
              end
            end
          end
          if (un == `TWI_SEQ_END) begin
            d.unit = '0;
            d.bitn = '0;
            if (q.st == S_START) begin
              d.scl_oe = 1'b1;
              d.st = S_BIT;
            end else begin
              d.st = S_IDLE;
            end
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '{st: S_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign rsp_valid = q.rsp_valid;
  assign rsp = q.rsp;
  assign bus_busy = q.busy;
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe = q.sda_oe;
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe = q.scl_oe;

  logic [`TWI_PRE_W-1:0] gap_q;
  logic seen_q;
  logic [`TWI_PRE_W-1:0] span_q;
  // Span is latched at each reload so a divider change mid-unit is not flagged
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gap_q <= '0;
      seen_q <= 1'b0;
      span_q <= '0;
    end else begin
      gap_q <= tick ? '0 : gap_q + `TWI_PRE_W'(1);
      seen_q <= seen_q || tick;
      span_q <= tick ? {clock_divider_value, 1'b1} : span_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_idle_not_busy: assert property (bus_idle |-> !bus_busy) else $error("idle with busy set"); // R1
  chk_busy_set: assert property (start_det |=> bus_busy) else $error("busy not set on start"); // R6
  chk_busy_clear: assert property (stop_det |=> !bus_busy) else $error("busy not cleared on stop"); // R6
  chk_tick_gap: assert property (tick && seen_q |-> gap_q == span_q)
    else $error("unit tick spacing wrong"); // R21
  chk_data_stable: assert property (q.st == S_BIT && !q.scl_oe && $past(!q.scl_oe) |-> $stable(q.sda_oe))
    else $error("data moved while clock high"); // R9
  chk_start_idle: assert property (q.st == S_IDLE && d.st == S_START |-> bus_idle)
    else $error("start on busy bus"); // R14
  chk_lost_release: assert property (rsp_valid && rsp.lost |-> !serial_data_pin_oe && !serial_clock_pin_oe ##1 q.st == S_IDLE)
    else $error("lines held after lost arbitration"); // R15
  chk_ack_release: assert property (q.st == S_BIT && q.bitn == `TWI_ACK_BIT && q.cmd.op != OP_READ && q.unit >= `TWI_LOW_UNITS
    |-> !serial_data_pin_oe) else $error("transmitter held ack slot"); // R10
  chk_nack_stop: assert property (rsp_valid && rsp.nack && q.cmd.op == OP_START |-> q.st == S_STOP)
    else $error("no stop after address nack"); // R12
  chk_stretch_hold: assert property (tick && q.st == S_BIT && q.unit >= `TWI_LOW_UNITS && !q.scl_oe && !scl_s
    |=> $stable(q.unit)) else $error("unit advanced during stretch"); // R4

  cov_byte_done: cover property (rsp_valid && !rsp.lost && !rsp.nack);
  cov_read_last: cover property (rsp_valid && q.cmd.op == OP_READ && q.cmd.last);
  cov_arb_lost: cover property (rsp_valid && rsp.lost);
  cov_stretch: cover property (tick && q.st == S_BIT && q.unit >= `TWI_LOW_UNITS && !q.scl_oe && !scl_s);
endmodule : twi_master_engine

// file: verilog/dummy_removed.sv
`timescale 1ns/1ps

// file: dv/twi_slave_model.sv
`timescale 1ns/1ps
module twi_slave_model #(
  parameter logic [6:0] ADDR = 7'h3B
) (
  input wire logic sda,
  input wire logic scl,
  input wire logic [7:0] tx_byte,
  input wire logic stretch,
  output logic sda_oe,
  output logic scl_oe,
  output logic [7:0] rx_byte
);
  int bitc;
  logic sel, rd, adr;
  logic [7:0] sh;
  initial begin
    {sda_oe, scl_oe, sel, rd, adr} = '0;
    bitc = 0;
    sh = 8'h00;
    rx_byte = 8'h00;
  end
  always @(negedge sda) if (scl) begin
    bitc = 0;
    adr = 1'b1;
    sel = 1'b0;
  end
  always @(posedge sda) if (scl) sel = 1'b0;
  always @(posedge scl) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else begin
      if (rd && sda) sel = 1'b0;
      adr = 1'b0;
    end
    bitc = (bitc == 8) ? 0 : bitc + 1;
  end
  // Lines change only after the clock falls, never while it is high
  always @(negedge scl) begin
    if (bitc == 8) begin
      if (adr) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (sel && !rd) rx_byte = sh;
      sda_oe = sel && (adr || !rd);
    end else begin
      // Data is set before any stretch so it is settled when the clock rises
      sda_oe = sel && rd && !tx_byte[7 - bitc];
      if (bitc == 0 && sel && stretch) begin
        scl_oe = 1'b1;
        #800;
        scl_oe = 1'b0;
      end
    end
  end
endmodule : twi_slave_model

// file: dv/tb_two_wire_bus_master_slave.sv
`timescale 1ns/1ps
module tb_two_wire_bus_master_slave;
  import twi_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] div = 8'h01;
  logic cmd_valid = 1'b0;
  cmd_t cmd = '0;
  logic arb_oe = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic cmd_ready, rsp_valid, bus_busy, sda_oe_m, scl_oe_m, sda_oe_s, scl_oe_s;
  logic [7:0] rx_byte;
  rsp_t rsp;
  wire sda_l = !(sda_oe_m || sda_oe_s || arb_oe);
  wire scl_l = !(scl_oe_m || scl_oe_s);
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h4F2D;
  realtime t0;
  always #5 clk = ~clk;
  twi_master_engine dut_u (.clk(clk), .rst_b(rst_b), .clock_divider_value(div), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .bus_busy(bus_busy),
    .serial_data_pin_in(sda_l), .serial_data_pin_out(), .serial_data_pin_oe(sda_oe_m),
    .serial_clock_pin_in(scl_l), .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe_m));
  twi_slave_model slave_u (.sda(sda_l), .scl(scl_l), .tx_byte(tx_byte), .stretch(stretch),
    .sda_oe(sda_oe_s), .scl_oe(scl_oe_s), .rx_byte(rx_byte));
  function automatic logic [31:0] rnd(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    rnd = x ^ (x << 5);
  endfunction : rnd
  function automatic cmd_t mk(input op_t op, input logic last, input logic [6:0] a, input logic dir,
    input logic [7:0] d);
    mk = '{op: op, last: last, addr: a, dir: dir, data: d};
  endfunction : mk
  task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp_val
  task automatic cmp_rsp(input rsp_t e);
    checks_done++;
    if (rsp !== e) begin
      n_mismatch++;
      $display("MISMATCH rsp expected %h seen %h", e, rsp);
    end
  endtask : cmp_rsp
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic push(input cmd_t c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : push
  task automatic get_rsp();
    int n = 0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    cmp_val("rsp_valid", 1, rsp_valid);
  endtask : get_rsp
  task automatic wait_idle();
    int n = 0;
    while (bus_busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    cmp_val("bus_busy", 0, bus_busy);
  endtask : wait_idle
  task automatic xfer(input logic [7:0] d0);
    push(mk(OP_START, 1'b0, 7'h3B, 1'b0, 8'h00));
    push(mk(OP_WRITE, 1'b0, 7'h00, 1'b0, d0));
    push(mk(OP_START, 1'b0, 7'h3B, 1'b1, 8'h00));
    push(mk(OP_READ, 1'b0, 7'h00, 1'b0, 8'h00));
    push(mk(OP_READ, 1'b1, 7'h00, 1'b0, 8'h00));
    push(mk(OP_STOP, 1'b0, 7'h00, 1'b0, 8'h00));
    @(posedge scl_l);
    t0 = $realtime;
    @(posedge scl_l);
    cmp_val("scl_period", 200 * (div + 1), int'($realtime - t0));
    get_rsp();
    cmp_rsp('{8'h76, 1'b0, 1'b0});
    cmp_val("bus_busy", 1, bus_busy);
    get_rsp();
    cmp_rsp('{d0, 1'b0, 1'b0});
    cmp_val("rx_byte", d0, rx_byte);
    get_rsp();
    cmp_rsp('{8'h77, 1'b0, 1'b0});
    get_rsp();
    cmp_rsp('{tx_byte, 1'b0, 1'b0});
    get_rsp();
    cmp_rsp('{tx_byte, 1'b1, 1'b0});
    wait_idle();
  endtask : xfer
  initial begin
    #900us;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      seed = rnd(seed);
      div <= 8'h01 + 8'(seed[7:0] % 3);
      tx_byte <= seed[15:8];
      stretch <= (i != 1);
      xfer(i == 1 ? 8'h80 : seed[31:24]);
    end
    push(mk(OP_START, 1'b0, 7'h12, 1'b0, 8'h00));
    get_rsp();
    cmp_rsp('{8'h24, 1'b1, 1'b0});
    wait_idle();
    // A rival master pulls data low while this one sends a one
    push(mk(OP_START, 1'b0, 7'h7F, 1'b1, 8'h00));
    @(negedge scl_l);
    @(posedge clk);
    arb_oe <= 1'b1;
    get_rsp();
    cmp_val("lost", 1, rsp.lost);
    repeat (2) @(negedge clk);
    cmp_val("oe", 0, {sda_oe_m, scl_oe_m});
    @(posedge clk);
    arb_oe <= 1'b0;
    wait_idle();
    summarize();
  end
endmodule : tb_two_wire_bus_master_slave
